// ---- rtl/rcm_regbank.sv ----
// rtc control register bank: byte registers, pointer, control_status_one, divider and clock out
// What this block does
// - unimplemented register bit positions always read back as zero
// - undefined bits come up arbitrary and keep their contents across resets
// - stop bit high halts rtc clock and clears the divider chain
// - clock output keeps its three highest frequencies while the rtc is stopped
// - bit 7 of control one selects external clock test mode
// - tamper pin at mid level sets bit 4; software clears it
// - bit 3 of control one enables the power-on reset override facility
// - bit 2 selects 12-hour mode with afternoon indicator, else 24-hour
// - hour alarm holds bcd hours with enable in bit 7
// - thirty byte registers; the lowest three are control and status
// - pointer increments per byte up to 1bh, then wraps to 00h
// - time counters freeze while clock or calendar registers are accessed
module rcm_regbank
    import rcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_xfer_active,
    input wire logic i_ptr_load,
    input wire logic [7:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_rd,
    input wire logic i_tamper_mid,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic [7:0] o_ptr,
    output logic o_clock_output_pin,
    output logic o_second_tick,
    output logic o_counters_frozen,
    output logic o_tamper_irq,
    output logic o_external_clock_test_select,
    output logic o_power_on_reset_override_enable,
    output logic o_mode_12h,
    output logic o_rtc_stopped,
    output logic o_hour_alarm_enable
);
    rcm_ctrl1_s ctrl1_r, ctrl1_nxt;
    logic [7:0] ctrl2_r, ctrl2_nxt, ctrl3_r, ctrl3_nxt;
    logic [7:0] clock_output_control_r, clock_output_control_nxt, timer_ctl_r, timer_ctl_nxt;
    logic [7:0] aging_r, aging_nxt, ram_hi_r, ram_hi_nxt, ram_lo_r, ram_lo_nxt;
    logic [7:0] ptr_r, ptr_nxt, raddr_r, raddr_nxt;
    logic rd_d1_r, rd_d1_nxt, rvalid_r, rvalid_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [SYNC_STAGES-1:0] tamper_sync_r;
    logic [31:0] nco_r, nco_nxt;
    logic tick_r, tick_nxt;
    logic [2:0] fast_r, fast_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic sec_pend_r, sec_pend_nxt, sec_tick_r, sec_tick_nxt;
    logic time_touched_r, time_touched_nxt, clock_output_pin_r, clock_output_pin_nxt;
    logic hour_alarm_en_r;
    logic [7:0] mem_rdata, acc_addr, wmask, wval;
    logic mem_we, in_map, is_flop_reg, time_access;

    // access address: a pointer load and a data strobe in one cycle uses the new address
    assign acc_addr = i_ptr_load ? i_addr : ptr_r;
    assign in_map = acc_addr < 8'(REG_COUNT);
    assign wmask = rcm_bit_mask(acc_addr);
    assign wval = i_wdata & wmask;
    assign is_flop_reg = (acc_addr <= ADDR_CTRL3) || (acc_addr >= ADDR_CLOCK_OUTPUT_CONTROL
        && acc_addr <= ADDR_TIMER_CTL) || (acc_addr >= ADDR_AGING && acc_addr <= ADDR_RAM_LO);
    // timestamp registers are read-only; ram command ports hold no storage here
    assign mem_we = i_wr && in_map && !is_flop_reg && !(acc_addr >= ADDR_TS_FIRST
        && acc_addr <= ADDR_TS_LAST) && acc_addr < ADDR_RAM_WR;
    assign time_access = (i_wr || i_rd) && acc_addr >= ADDR_TIME_FIRST
        && acc_addr <= ADDR_TIME_LAST;

    rcm_reg_mem u_mem (
        .i_clk(i_clk),
        .i_we(mem_we),
        .i_waddr(acc_addr[4:0]),
        .i_wdata(wval),
        .i_raddr(acc_addr[4:0]),
        .o_rdata(mem_rdata)
    );

    // hour alarm enable shadow keeps its contents over reset like the stored byte
    always_ff @(posedge i_clk) begin
        if (i_wr && acc_addr == ADDR_HOUR_ALARM) begin
            hour_alarm_en_r <= i_wdata[BIT_HOUR_ALARM_EN];
        end
    end

    // register file, pointer and read path
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        ctrl3_nxt = ctrl3_r;
        clock_output_control_nxt = clock_output_control_r;
        timer_ctl_nxt = timer_ctl_r;
        aging_nxt = aging_r;
        ram_hi_nxt = ram_hi_r;
        ram_lo_nxt = ram_lo_r;
        ptr_nxt = ptr_r;
        raddr_nxt = raddr_r;
        rd_d1_nxt = 1'b0;
        rvalid_nxt = rd_d1_r;
        rdata_nxt = rdata_r;
        if (i_ptr_load) begin
            ptr_nxt = i_addr;
        end
        if (i_wr && in_map) begin
            case (acc_addr)
                ADDR_CTRL1: begin
                    ctrl1_nxt = rcm_ctrl1_s'(i_wdata);
                    // flag: zero clears, one keeps
                    ctrl1_nxt.tamper_flag = ctrl1_r.tamper_flag
                        & i_wdata[BIT_TAMPER_FLAG];
                end
                ADDR_CTRL2: ctrl2_nxt = i_wdata;
                ADDR_CTRL3: ctrl3_nxt = i_wdata;
                ADDR_CLOCK_OUTPUT_CONTROL: clock_output_control_nxt = wval;
                ADDR_TIMER_CTL: timer_ctl_nxt = wval;
                ADDR_AGING: aging_nxt = wval;
                ADDR_RAM_HI: ram_hi_nxt = wval;
                ADDR_RAM_LO: ram_lo_nxt = wval;
                default: ;
            endcase
        end
        // a mid-level pin wins over a clearing write in the same cycle
        if (tamper_sync_r[SYNC_STAGES-1]) begin
            ctrl1_nxt.tamper_flag = 1'b1;
        end
        if (i_rd) begin
            raddr_nxt = acc_addr;
            rd_d1_nxt = 1'b1;
        end
        if (rd_d1_r) begin
            case (raddr_r)
                ADDR_CTRL1: rdata_nxt = ctrl1_r;
                ADDR_CTRL2: rdata_nxt = ctrl2_r;
                ADDR_CTRL3: rdata_nxt = ctrl3_r;
                ADDR_CLOCK_OUTPUT_CONTROL: rdata_nxt = clock_output_control_r;
                ADDR_TIMER_CTL: rdata_nxt = timer_ctl_r;
                ADDR_AGING: rdata_nxt = aging_r;
                ADDR_RAM_HI: rdata_nxt = ram_hi_r;
                ADDR_RAM_LO: rdata_nxt = ram_lo_r;
                default: rdata_nxt = mem_rdata & rcm_bit_mask(raddr_r);
            endcase
        end
        // ram command ports are reached only by direct address and hold the pointer
        if ((i_wr || i_rd) && acc_addr <= ADDR_WRAP_LAST) begin
            ptr_nxt = (acc_addr == ADDR_WRAP_LAST) ? ADDR_CTRL1 : acc_addr + 8'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl1_r <= rcm_ctrl1_s'(RST_CTRL);
            ctrl2_r <= RST_CTRL;
            ctrl3_r <= RST_CTRL;
            clock_output_control_r <= RST_CLOCK_OUTPUT_CONTROL;
            timer_ctl_r <= RST_TIMER_CTL;
            aging_r <= RST_AGING;
            ram_hi_r <= RST_RAM_ADDR;
            ram_lo_r <= RST_RAM_ADDR;
            ptr_r <= ADDR_CTRL1;
            raddr_r <= ADDR_CTRL1;
            rd_d1_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            ctrl3_r <= ctrl3_nxt;
            clock_output_control_r <= clock_output_control_nxt;
            timer_ctl_r <= timer_ctl_nxt;
            aging_r <= aging_nxt;
            ram_hi_r <= ram_hi_nxt;
            ram_lo_r <= ram_lo_nxt;
            ptr_r <= ptr_nxt;
            raddr_r <= raddr_nxt;
            rd_d1_r <= rd_d1_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // tamper pin comes from outside: two stages before any use
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tamper_sync_r <= '0;
        end else begin
            tamper_sync_r <= {tamper_sync_r[SYNC_STAGES-2:0], i_tamper_mid};
        end
    end

    // oscillator tick, divider chain, second carry and clock output
    always_comb begin
        logic [32:0] sum;
        sum = {1'b0, nco_r} + {1'b0, NCO_INC};
        nco_nxt = sum[31:0];
        tick_nxt = sum[32];
        fast_nxt = fast_r;
        div_nxt = div_r;
        sec_pend_nxt = sec_pend_r;
        sec_tick_nxt = 1'b0;
        time_touched_nxt = i_xfer_active && (time_touched_r || time_access);
        clock_output_pin_nxt = clock_output_pin_r;
        if (tick_r) begin
            // the oscillator itself keeps running for the fast clock output
            fast_nxt = fast_r + 3'h1;
            if (!ctrl1_r.stop) begin
                div_nxt = div_r + 16'h0001;
                if (div_r == '1) begin
                    sec_pend_nxt = 1'b1;
                end
            end
        end
        if (ctrl1_r.stop) begin
            div_nxt = '0;
            sec_pend_nxt = 1'b0;
        end
        // carry held back until the transfer ends, so no value tears
        if (sec_pend_r && !time_touched_r) begin
            sec_tick_nxt = 1'b1;
            sec_pend_nxt = 1'b0;
        end
        case (clock_output_control_r[COF_LSB+:3])
            COF_32K: clock_output_pin_nxt = fast_r[0];
            COF_16K: clock_output_pin_nxt = fast_r[1];
            COF_8K: clock_output_pin_nxt = fast_r[2];
            COF_4K: clock_output_pin_nxt = div_r[3];
            COF_2K: clock_output_pin_nxt = div_r[4];
            COF_1K: clock_output_pin_nxt = div_r[5];
            COF_1HZ: clock_output_pin_nxt = div_r[DIV_W-1];
            default: clock_output_pin_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            nco_r <= '0;
            tick_r <= 1'b0;
            fast_r <= '0;
            div_r <= '0;
            sec_pend_r <= 1'b0;
            sec_tick_r <= 1'b0;
            time_touched_r <= 1'b0;
            clock_output_pin_r <= 1'b0;
        end else begin
            nco_r <= nco_nxt;
            tick_r <= tick_nxt;
            fast_r <= fast_nxt;
            div_r <= div_nxt;
            sec_pend_r <= sec_pend_nxt;
            sec_tick_r <= sec_tick_nxt;
            time_touched_r <= time_touched_nxt;
            clock_output_pin_r <= clock_output_pin_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_rvalid = rvalid_r;
    assign o_ptr = ptr_r;
    assign o_clock_output_pin = clock_output_pin_r;
    assign o_second_tick = sec_tick_r;
    assign o_counters_frozen = time_touched_r;
    assign o_tamper_irq = ctrl1_r.tamper_flag;
    assign o_external_clock_test_select = ctrl1_r.external_clock_test_select;
    assign o_power_on_reset_override_enable = ctrl1_r.power_on_reset_override_enable;
    assign o_mode_12h = ctrl1_r.mode_12h;
    assign o_rtc_stopped = ctrl1_r.stop;
    assign o_hour_alarm_enable = hour_alarm_en_r;

    a_flag_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
        tamper_sync_r[SYNC_STAGES-1] |=> ctrl1_r.tamper_flag)
        else $error("tamper flag not set");
    a_flag_write_one_keeps: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr && acc_addr == ADDR_CTRL1 && i_wdata[BIT_TAMPER_FLAG] && ctrl1_r.tamper_flag)
        |=> ctrl1_r.tamper_flag)
        else $error("writing one changed the flag");
    a_flag_write_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr && acc_addr == ADDR_CTRL1 && !i_wdata[BIT_TAMPER_FLAG]
        && !tamper_sync_r[SYNC_STAGES-1]) |=> !ctrl1_r.tamper_flag)
        else $error("writing zero did not clear the flag");
    a_stop_clears_div: assert property (@(posedge i_clk) disable iff (i_rst)
        ctrl1_r.stop |=> div_r == '0)
        else $error("divider chain not held at zero");
    a_ptr_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_wr || i_rd) && acc_addr == ADDR_WRAP_LAST |=> ptr_r == ADDR_CTRL1)
        else $error("pointer did not wrap");
    a_ptr_incr: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && acc_addr < ADDR_WRAP_LAST && !i_ptr_load) |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer did not increment");
    a_read_masked: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_d1_r |=> (rdata_r & ~rcm_bit_mask($past(raddr_r))) == 8'h00)
        else $error("unimplemented bit read as one");
    a_frozen_no_tick: assert property (@(posedge i_clk) disable iff (i_rst)
        time_touched_r |=> !sec_tick_r)
        else $error("second carry during a frozen transfer");
    a_read_latency: assert property (@(posedge i_clk) disable iff (i_rst)
        i_rd |-> ##2 o_rvalid)
        else $error("read answer not two cycles later");
    a_fast_clock_output_pin_stop: assert property (@(posedge i_clk) disable iff (i_rst)
        ctrl1_r.stop && tick_r |=> fast_r == $past(fast_r) + 3'h1)
        else $error("fast clock output halted by stop");
    c_tamper_clear: cover property (@(posedge i_clk) disable iff (i_rst)
        ctrl1_r.tamper_flag ##1 !ctrl1_r.tamper_flag);
    c_wrap: cover property (@(posedge i_clk) disable iff (i_rst)
        i_rd && acc_addr == ADDR_WRAP_LAST ##1 i_rd && acc_addr == ADDR_CTRL1);
    c_sec_tick: cover property (@(posedge i_clk) disable iff (i_rst) sec_tick_r);
    c_stop: cover property (@(posedge i_clk) disable iff (i_rst)
        ctrl1_r.stop && clock_output_pin_r != $past(clock_output_pin_r));
endmodule : rcm_regbank

// ---- rtl/rcm_pkg.sv ----
// package: register map, field positions, reset values and timing for the rtc register bank
package rcm_pkg;
    localparam int unsigned REG_COUNT = 30;
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h01;
    localparam logic [7:0] ADDR_CTRL3 = 8'h02;
    localparam logic [7:0] ADDR_TIME_FIRST = 8'h03;
    localparam logic [7:0] ADDR_TIME_LAST = 8'h09;
    localparam logic [7:0] ADDR_HOUR_ALARM = 8'h0c;
    localparam logic [7:0] ADDR_CLOCK_OUTPUT_CONTROL = 8'h0f;
    localparam logic [7:0] ADDR_TIMER_CTL = 8'h10;
    localparam logic [7:0] ADDR_TS_FIRST = 8'h13;
    localparam logic [7:0] ADDR_TS_LAST = 8'h18;
    localparam logic [7:0] ADDR_AGING = 8'h19;
    localparam logic [7:0] ADDR_RAM_HI = 8'h1a;
    localparam logic [7:0] ADDR_RAM_LO = 8'h1b;
    localparam logic [7:0] ADDR_RAM_WR = 8'h1c;
    localparam logic [7:0] ADDR_RAM_RD = 8'h1d;
    localparam logic [7:0] ADDR_WRAP_LAST = ADDR_RAM_LO;
    // control_status_one, hour alarm and clock-output field positions
    localparam int unsigned BIT_EXTERNAL_CLOCK_TEST_SELECT = 7;
    localparam int unsigned BIT_TEST = 6;
    localparam int unsigned BIT_STOP = 5;
    localparam int unsigned BIT_TAMPER_FLAG = 4;
    localparam int unsigned BIT_POWER_ON_RESET_OVERRIDE_ENABLE = 3;
    localparam int unsigned BIT_MODE_12H = 2;
    localparam int unsigned BIT_HOUR_ALARM_EN = 7;
    localparam int unsigned COF_LSB = 0;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CLOCK_OUTPUT_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_CTL = 8'h03;
    localparam logic [7:0] RST_AGING = 8'h08;
    localparam logic [7:0] RST_RAM_ADDR = 8'h00;
    // clock-output frequency selections
    localparam logic [2:0] COF_32K = 3'h0;
    localparam logic [2:0] COF_16K = 3'h1;
    localparam logic [2:0] COF_8K = 3'h2;
    localparam logic [2:0] COF_4K = 3'h3;
    localparam logic [2:0] COF_2K = 3'h4;
    localparam logic [2:0] COF_1K = 3'h5;
    localparam logic [2:0] COF_1HZ = 3'h6;
    // timing: 65.536 kHz tick from the 20 MHz system clock by phase accumulator
    localparam longint unsigned SYS_CLK_HZ = 20000000;
    localparam longint unsigned TICK_HZ = 65536;
    localparam logic [31:0] NCO_INC = 32'((TICK_HZ << 32) / SYS_CLK_HZ);
    localparam int unsigned DIV_W = 16;
    localparam int unsigned SYNC_STAGES = 2;

    typedef struct packed {
        logic external_clock_test_select;
        logic test;
        logic stop;
        logic tamper_flag;
        logic power_on_reset_override_enable;
        logic mode_12h;
        logic minute_irq_en;
        logic second_irq_en;
    } rcm_ctrl1_s;

    // unimplemented bit positions read as zero
    function automatic logic [7:0] rcm_bit_mask(input logic [7:0] a);
        case (a)
            8'h04, 8'h13, 8'h14: rcm_bit_mask = 8'h7f;
            8'h05, 8'h06, 8'h15, 8'h16: rcm_bit_mask = 8'h3f;
            8'h07: rcm_bit_mask = 8'h07;
            8'h08, 8'h17: rcm_bit_mask = 8'h1f;
            8'h0c, 8'h0d: rcm_bit_mask = 8'hbf;
            8'h0e: rcm_bit_mask = 8'h87;
            8'h0f: rcm_bit_mask = 8'hc7;
            8'h10: rcm_bit_mask = 8'he3;
            8'h12: rcm_bit_mask = 8'hdf;
            8'h19: rcm_bit_mask = 8'h0f;
            8'h1a: rcm_bit_mask = 8'h01;
            8'h1c, 8'h1d: rcm_bit_mask = 8'h00;
            default: rcm_bit_mask = (a < 8'(REG_COUNT)) ? 8'hff : 8'h00;
        endcase
    endfunction : rcm_bit_mask
endpackage : rcm_pkg

// ---- rtl/rcm_reg_mem.sv ----
// storage for registers whose contents are undefined at power-on and kept over resets
module rcm_reg_mem
    import rcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [4:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [4:0] i_raddr,
    output logic [7:0] o_rdata
);
    // no reset on purpose: contents survive every reset
    logic [7:0] mem [REG_COUNT];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : rcm_reg_mem

// ---- verif/rcm_host_model.sv ----
// host model: drives the byte strobe port the way the serial host would
module rcm_host_model
    import rcm_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_xfer_active,
    output logic o_ptr_load,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_xfer_active = 1'b0;
        o_ptr_load = 1'b0;
        o_addr = 8'h5a;
        o_wr = 1'b0;
        o_wdata = 8'ha5;
        o_rd = 1'b0;
    end
    task automatic frame(input logic on);
        @(negedge i_clk);
        o_xfer_active = on;
    endtask : frame
    // released lines show the inverse so a stale value cannot pass as a match
    task automatic wr(input logic ld, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_ptr_load = ld;
        o_addr = a;
        o_wdata = (ld && a == ADDR_CTRL1) ? (d & 8'hbf) : d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_ptr_load = 1'b0;
        o_wdata = ~o_wdata;
        o_addr = ~a;
    endtask : wr
    task automatic rd(input logic ld, input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge i_clk);
        o_ptr_load = ld;
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_ptr_load = 1'b0;
        o_addr = ~a;
        d = 8'hxx;
        for (n = 0; n < 4 && i_rvalid !== 1'b1; n++) begin
            @(negedge i_clk);
        end
        if (i_rvalid === 1'b1) begin
            d = i_rdata;
        end
    endtask : rd
endmodule : rcm_host_model

// ---- verif/tb_top.sv ----
// self-checking bench for the rtc register bank
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h got %h", nm, e, g); end end
module tb_top
    import rcm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, tamper = 1'b0, xfer, ld, wr, rd, rvalid, ck_pin;
    logic [7:0] addr, wdata, rdata, ptr, d;
    logic tick, frozen, irq, external_clock_test_select, reset_override_facility, mode12, stopped, alarm_en;
    int fail_count = 0, tests_run = 0, cycles = 0;
    always #25 clk = ~clk;
    rcm_host_model rcm_host_model_inst (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_xfer_active(xfer), .o_ptr_load(ld), .o_addr(addr), .o_wr(wr), .o_wdata(wdata),
        .o_rd(rd));
    rcm_regbank rcm_regbank_inst (.i_clk(clk), .i_rst(rst), .i_xfer_active(xfer),
        .i_ptr_load(ld), .i_addr(addr), .i_wr(wr), .i_wdata(wdata), .i_rd(rd),
        .i_tamper_mid(tamper), .o_rdata(rdata), .o_rvalid(rvalid), .o_ptr(ptr),
        .o_clock_output_pin(ck_pin), .o_second_tick(tick), .o_counters_frozen(frozen),
        .o_tamper_irq(irq), .o_external_clock_test_select(external_clock_test_select),
        .o_power_on_reset_override_enable(reset_override_facility), .o_mode_12h(mode12),
        .o_rtc_stopped(stopped), .o_hour_alarm_enable(alarm_en));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    // hang guard, under four times the roughly 8100 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic toggles(input int n, output int cnt);
        logic prev;
        cnt = 0;
        prev = ck_pin;
        repeat (n) begin
            @(negedge clk);
            if (ck_pin !== prev) cnt++;
            prev = ck_pin;
        end
    endtask : toggles
    task automatic t_reset_vals();
        logic [7:0] a[6] = '{8'h00, 8'h0f, 8'h10, 8'h19, 8'h1a, 8'h1b};
        logic [7:0] e[6] = '{8'h00, 8'h00, 8'h03, 8'h08, 8'h00, 8'h00};
        `CHK("ptr", 8'h00, ptr)
        foreach (a[i]) begin
            rcm_host_model_inst.rd(1'b1, a[i], d);
            `CHK("reset value", e[i], d)
        end
        $display("test reset_vals done");
    endtask : t_reset_vals
    task automatic t_masks();
        logic [7:0] a[4] = '{8'h0f, 8'h19, 8'h1a, 8'h1e};
        logic [7:0] e[4] = '{8'hc7, 8'h0f, 8'h01, 8'h00};
        foreach (a[i]) begin
            rcm_host_model_inst.wr(1'b1, a[i], 8'hff);
            rcm_host_model_inst.rd(1'b1, a[i], d);
            `CHK("masked read", e[i], d)
        end
        $display("test masks done");
    endtask : t_masks
    task automatic t_ctrl_stop();
        int c;
        rcm_host_model_inst.wr(1'b1, 8'h00, 8'hec);
        `CHK("external_clock_test_select", 1'b1, external_clock_test_select)
        `CHK("stopped", 1'b1, stopped)
        `CHK("override", 1'b1, reset_override_facility)
        `CHK("mode 12h", 1'b1, mode12)
        rcm_host_model_inst.wr(1'b1, 8'h0f, {5'h00, COF_32K});
        toggles(2000, c);
        `CHK("fast clock_output_pin runs", 1'b1, c >= 4)
        rcm_host_model_inst.wr(1'b1, 8'h0f, {5'h00, COF_4K});
        repeat (4) @(negedge clk);
        // a running 4 khz divider toggles within eight ticks of about 305 cycles
        toggles(3000, c);
        `CHK("slow clock_output_pin held", 0, c)
        rcm_host_model_inst.wr(1'b1, 8'h00, 8'h00);
        `CHK("runs again", 1'b0, stopped)
        `CHK("normal mode", 1'b0, external_clock_test_select)
        `CHK("override off", 1'b0, reset_override_facility)
        toggles(3000, c);
        `CHK("slow clock_output_pin resumes", 1'b1, c >= 1)
        `CHK("24h mode", 1'b0, mode12)
        $display("test ctrl_stop done");
    endtask : t_ctrl_stop
    task automatic t_pointer();
        rcm_host_model_inst.wr(1'b1, 8'h1b, 8'h12);
        `CHK("wrap", 8'h00, ptr)
        rcm_host_model_inst.wr(1'b0, 8'h00, 8'h00);
        `CHK("increment", 8'h01, ptr)
        rcm_host_model_inst.rd(1'b1, 8'h1c, d);
        `CHK("ram port holds", 8'h1c, ptr)
        `CHK("ram port reads zero", 8'h00, d)
        $display("test pointer done");
    endtask : t_pointer
    task automatic t_tamper();
        @(negedge clk);
        tamper = 1'b1;
        repeat (5) @(negedge clk);
        tamper = 1'b0;
        // let the synchroniser drain so only the write decides the flag
        repeat (3) @(negedge clk);
        `CHK("flag set", 1'b1, irq)
        rcm_host_model_inst.wr(1'b1, 8'h00, 8'h10);
        `CHK("write one keeps", 1'b1, irq)
        rcm_host_model_inst.rd(1'b1, 8'h00, d);
        `CHK("flag bit", 8'h10, d)
        rcm_host_model_inst.wr(1'b1, 8'h00, 8'h00);
        `CHK("write zero clears", 1'b0, irq)
        $display("test tamper done");
    endtask : t_tamper
    task automatic t_freeze();
        rcm_host_model_inst.frame(1'b1);
        rcm_host_model_inst.rd(1'b1, 8'h03, d);
        `CHK("frozen", 1'b1, frozen)
        `CHK("no carry while frozen", 1'b0, tick)
        rcm_host_model_inst.frame(1'b0);
        repeat (3) @(negedge clk);
        `CHK("released", 1'b0, frozen)
        $display("test freeze done");
    endtask : t_freeze
    task automatic t_alarm();
        rcm_host_model_inst.wr(1'b1, 8'h0c, 8'h92);
        `CHK("alarm on", 1'b1, alarm_en)
        rcm_host_model_inst.rd(1'b1, 8'h0c, d);
        `CHK("alarm 12h", 8'h92, d)
        rcm_host_model_inst.wr(1'b1, 8'h0c, 8'h23);
        `CHK("alarm off", 1'b0, alarm_en)
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK("ptr after reset", 8'h00, ptr)
        `CHK("alarm enable kept", 1'b0, alarm_en)
        rcm_host_model_inst.rd(1'b1, 8'h0c, d);
        `CHK("kept over reset", 8'h23, d)
        $display("test alarm done");
    endtask : t_alarm
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_reset_vals();
        t_masks();
        t_ctrl_stop();
        t_pointer();
        t_tamper();
        t_freeze();
        t_alarm();
        stop_test();
    end
endmodule : tb_top
